// file: include/phy_ctrl_pkg.sv
// Shared constants for the LED and general PHY control register bank
package phy_ctrl_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_LAMP_CTRL = 6'h19;
	localparam logic [5:0] IDX_LAMP_BLINK = 6'h1a;
	localparam logic [5:0] IDX_GENERAL_CONFIG_FOUR = 6'h1e;
	localparam logic [5:0] IDX_GEN_RESET = 6'h1f;

	// Reset values
	localparam logic [15:0] RST_LAMP_CTRL = 16'h4444;
	localparam logic [15:0] RST_LAMP_BLINK = 16'h0002;
	localparam logic [15:0] RST_GENERAL_CONFIG_FOUR = 16'h0012;
	localparam logic [15:0] RST_GEN_RESET = 16'h0000;

	// Lamp control layout: lamp k uses bits 4k (enable), 4k+1 (value), 4k+2 (polarity)
	localparam int LAMP_COUNT = 4;
	localparam int LAMP_STRIDE = 4;
	localparam int LAMP_FEN_POS = 0;
	localparam int LAMP_FVAL_POS = 1;
	localparam int LAMP_POL_POS = 2;
	localparam logic [15:0] LAMP_CTRL_RW_MASK = 16'h7777;

	// Blink and stretch register layout
	localparam int BLINK_SEL_POS = 0;
	localparam int STRETCH_BYPASS_POS = 2;
	localparam logic [15:0] LAMP_BLINK_RW_MASK = 16'h0007;

	// General configuration layout
	localparam int REFL_START_POS = 0;
	localparam int REFL_DONE_POS = 1;
	localparam int REFL_FAIL_POS = 2;
	localparam int GIG_ONLY_POS = 3;
	localparam int FORCE_IRQ_POS = 6;
	localparam int IRQ_OE_POS = 7;
	localparam int QUICK_XOVER_POS = 8;
	localparam int ROBUST_XOVER_POS = 9;
	localparam int STATUS_CLEAR_POS = 10;
	localparam int PD_FULL_DUPLEX_POS = 11;
	localparam int QUICK_NEG_SEL_POS = 12;
	localparam int QUICK_NEG_EN_POS = 14;
	localparam logic [15:0] GENERAL_CONFIG_FOUR_RW_MASK = 16'hfff8;

	// Reset control layout
	localparam int SOFT_RESTART_POS = 14;
	localparam int SOFT_RESET_POS = 15;
	localparam logic [15:0] GEN_RESET_RW_MASK = 16'h3fff;

	// Lamp source code that combines link with blinking activity
	localparam logic [3:0] SRC_LINK_BLINK = 4'hb;
	localparam int SRC_LINK_BIT = 0;
	localparam int SRC_ACT_BIT = 1;

	// Blink timing
	localparam int CLK_HZ = 10_000_000;
	localparam int BLINK_MS_0 = 50;
	localparam int BLINK_MS_1 = 100;
	localparam int BLINK_MS_2 = 200;
	localparam int BLINK_MS_3 = 500;
	localparam int BLINK_HALF_0 = BLINK_MS_0 * (CLK_HZ / 1000) / 2;
	localparam int BLINK_HALF_1 = BLINK_MS_1 * (CLK_HZ / 1000) / 2;
	localparam int BLINK_HALF_2 = BLINK_MS_2 * (CLK_HZ / 1000) / 2;
	localparam int BLINK_HALF_3 = BLINK_MS_3 * (CLK_HZ / 1000) / 2;
	localparam int TIMER_W = 24;
endpackage : phy_ctrl_pkg

// file: hw/phy_ctrl_regs.sv
// LED and general PHY control register bank with a classic Wishbone slave
`timescale 1ns/1ps

module phy_ctrl_regs #(
	parameter int BLINK_HALF_0 = phy_ctrl_pkg::BLINK_HALF_0,
	parameter int BLINK_HALF_1 = phy_ctrl_pkg::BLINK_HALF_1,
	parameter int BLINK_HALF_2 = phy_ctrl_pkg::BLINK_HALF_2,
	parameter int BLINK_HALF_3 = phy_ctrl_pkg::BLINK_HALF_3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Lamp sources and pins
	input wire logic [15:0] lamp_events_i,
	input wire logic [3:0] lamp0_source_select_i,
	input wire logic [3:0] lamp1_source_select_i,
	input wire logic [3:0] lamp2_source_select_i,
	input wire logic [3:0] aux_lamp_source_select_i,
	input wire logic [3:0] strap_polarity_i,
	output logic [3:0] lamp_o,
	// Shared interrupt / power-down pad, open drain
	input wire logic irq_event_i,
	input wire logic irq_powerdown_pad_i,
	output logic irq_powerdown_pad_o,
	output logic irq_powerdown_pad_oe_o,
	output logic power_down_o,
	// Configuration to the PHY core
	output logic quick_negotiation_enable_o,
	output logic [1:0] quick_negotiation_timer_sel_o,
	output logic parallel_detect_full_duplex_o,
	output logic status_clear_o,
	output logic robust_crossover_enable_o,
	output logic quick_crossover_enable_o,
	output logic gigabit_only_negotiation_o,
	// Cable reflectometry
	output logic reflectometry_start_o,
	input wire logic reflectometry_complete_i,
	input wire logic reflectometry_failed_i,
	// Reset and restart pulses to the PHY core
	output logic soft_full_reset_o,
	output logic soft_restart_keep_regs_o
);
	localparam int N = phy_ctrl_pkg::LAMP_COUNT;
	localparam int TW = phy_ctrl_pkg::TIMER_W;

	logic [15:0] lamp_ctrl;
	logic [15:0] lamp_blink;
	logic [15:0] general_config_four;
	logic [15:0] gen_reset;
	logic [3:0] strap_meta;
	logic [3:0] strap_sync;
	logic [3:0] strap_latched;
	logic strap_taken;
	logic pad_meta;
	logic pad_sync;
	logic [TW-1:0] blink_cnt;
	logic blink_phase;
	logic [TW-1:0] blink_half;
	logic [N-1:0] lamp_raw;
	logic [N-1:0] lamp_shown;
	logic [3:0] lamp_sel [N];
	logic access;
	logic wr;
	logic [5:0] idx;
	logic [15:0] wmask;
	logic [15:0] wdata;
	logic [15:0] next_rdata;
	logic soft_reset_req;
	logic wr_lamp_ctrl;
	logic wr_lamp_blink;
	logic wr_general_config_four;
	logic wr_gen_reset;

	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = access && wb_we_i;
	assign idx = wb_adr_i[7:2];
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdata = wb_dat_i[15:0];
	assign soft_reset_req = gen_reset[phy_ctrl_pkg::SOFT_RESET_POS];

	// One write strobe per register, high on the edge that takes the request
	assign wr_lamp_ctrl = wr && idx == phy_ctrl_pkg::IDX_LAMP_CTRL;
	assign wr_lamp_blink = wr && idx == phy_ctrl_pkg::IDX_LAMP_BLINK;
	assign wr_general_config_four = wr && idx == phy_ctrl_pkg::IDX_GENERAL_CONFIG_FOUR;
	assign wr_gen_reset = wr && idx == phy_ctrl_pkg::IDX_GEN_RESET;

	assign lamp_sel[0] = lamp0_source_select_i;
	assign lamp_sel[1] = lamp1_source_select_i;
	assign lamp_sel[2] = lamp2_source_select_i;
	assign lamp_sel[3] = aux_lamp_source_select_i;

	// Bus handshake: one registered ack per request, the cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= access;
		end
	end

	always_comb begin
		next_rdata = 16'h0000;
		unique case (idx)
			phy_ctrl_pkg::IDX_LAMP_CTRL: next_rdata = lamp_ctrl;
			phy_ctrl_pkg::IDX_LAMP_BLINK: next_rdata = lamp_blink;
			phy_ctrl_pkg::IDX_GENERAL_CONFIG_FOUR: next_rdata = general_config_four;
			phy_ctrl_pkg::IDX_GEN_RESET: next_rdata = gen_reset;
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data, upper half and unmapped words read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i && access && !wb_we_i) begin
			wb_dat_o <= {16'h0000, next_rdata};
		end
	end

	// Strap pins pass two flops; the pair runs through reset so the latch sees the pins
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			strap_meta <= strap_polarity_i;
			strap_sync <= strap_meta;
		end
	end

	// Straps are latched at the first enabled edge after reset, kept for soft reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_taken <= 1'b0;
			strap_latched <= 4'hf;
		end else if (ce_i && !strap_taken) begin
			strap_taken <= 1'b1;
			strap_latched <= strap_sync;
		end
	end

	// Lamp polarity and force register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lamp_ctrl <= phy_ctrl_pkg::RST_LAMP_CTRL;
		end else if (ce_i) begin
			if (soft_reset_req || !strap_taken) begin
				lamp_ctrl <= phy_ctrl_pkg::RST_LAMP_CTRL;
				for (int k = 0; k < N; k++) begin
					lamp_ctrl[k * phy_ctrl_pkg::LAMP_STRIDE + phy_ctrl_pkg::LAMP_POL_POS] <=
						soft_reset_req ? strap_latched[k] : strap_sync[k];
				end
			end else if (wr_lamp_ctrl) begin
				lamp_ctrl <= (lamp_ctrl & ~(wmask & phy_ctrl_pkg::LAMP_CTRL_RW_MASK)) |
					(wdata & wmask & phy_ctrl_pkg::LAMP_CTRL_RW_MASK);
			end
		end
	end

	// Blink and stretch register
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && soft_reset_req)) begin
			lamp_blink <= phy_ctrl_pkg::RST_LAMP_BLINK;
		end else if (ce_i && wr_lamp_blink) begin
			lamp_blink <= (lamp_blink & ~(wmask & phy_ctrl_pkg::LAMP_BLINK_RW_MASK)) |
				(wdata & wmask & phy_ctrl_pkg::LAMP_BLINK_RW_MASK);
		end
	end

	// General configuration register, with the reflectometry start and flags
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && soft_reset_req)) begin
			general_config_four <= phy_ctrl_pkg::RST_GENERAL_CONFIG_FOUR;
		end else if (ce_i) begin
			if (wr_general_config_four) begin
				general_config_four[15:3] <= (general_config_four[15:3] & ~(wmask[15:3])) | (wdata[15:3] & wmask[15:3]);
				if (wmask[phy_ctrl_pkg::REFL_START_POS] && wdata[phy_ctrl_pkg::REFL_START_POS]) begin
					general_config_four[phy_ctrl_pkg::REFL_START_POS] <= 1'b1;
					general_config_four[phy_ctrl_pkg::REFL_DONE_POS] <= 1'b0;
					general_config_four[phy_ctrl_pkg::REFL_FAIL_POS] <= 1'b0;
				end
			end
			// Completion is the set and wins over a start in the same cycle
			if (reflectometry_complete_i && general_config_four[phy_ctrl_pkg::REFL_START_POS]) begin
				general_config_four[phy_ctrl_pkg::REFL_START_POS] <= 1'b0;
				general_config_four[phy_ctrl_pkg::REFL_DONE_POS] <= 1'b1;
				general_config_four[phy_ctrl_pkg::REFL_FAIL_POS] <= reflectometry_failed_i;
			end
		end
	end

	// Reset control: command bits hold for one cycle and self-clear
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && soft_reset_req)) begin
			gen_reset <= phy_ctrl_pkg::RST_GEN_RESET;
		end else if (ce_i) begin
			gen_reset[phy_ctrl_pkg::SOFT_RESTART_POS] <= 1'b0;
			if (wr_gen_reset) begin
				gen_reset[13:0] <= (gen_reset[13:0] & ~wmask[13:0]) | (wdata[13:0] & wmask[13:0]);
				gen_reset[phy_ctrl_pkg::SOFT_RESET_POS] <= wmask[15] &&
					wdata[phy_ctrl_pkg::SOFT_RESET_POS];
				gen_reset[phy_ctrl_pkg::SOFT_RESTART_POS] <= wmask[15] &&
					wdata[phy_ctrl_pkg::SOFT_RESTART_POS];
			end
		end
	end

	// Configuration copies to the PHY core, one cycle behind the register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			quick_negotiation_enable_o <= 1'b0;
			quick_negotiation_timer_sel_o <= 2'h0;
			parallel_detect_full_duplex_o <= 1'b0;
			status_clear_o <= 1'b0;
			robust_crossover_enable_o <= 1'b0;
			quick_crossover_enable_o <= 1'b0;
			gigabit_only_negotiation_o <= 1'b0;
		end else if (ce_i) begin
			quick_negotiation_enable_o <= general_config_four[phy_ctrl_pkg::QUICK_NEG_EN_POS];
			quick_negotiation_timer_sel_o <=
				general_config_four[phy_ctrl_pkg::QUICK_NEG_SEL_POS +: 2];
			parallel_detect_full_duplex_o <= general_config_four[phy_ctrl_pkg::PD_FULL_DUPLEX_POS];
			status_clear_o <= general_config_four[phy_ctrl_pkg::STATUS_CLEAR_POS];
			robust_crossover_enable_o <= general_config_four[phy_ctrl_pkg::ROBUST_XOVER_POS];
			quick_crossover_enable_o <= general_config_four[phy_ctrl_pkg::QUICK_XOVER_POS];
			gigabit_only_negotiation_o <= general_config_four[phy_ctrl_pkg::GIG_ONLY_POS];
		end
	end

	// Cable test runs while the start bit is held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reflectometry_start_o <= 1'b0;
		end else if (ce_i) begin
			reflectometry_start_o <= general_config_four[phy_ctrl_pkg::REFL_START_POS];
		end
	end

	// Reset and restart pulses, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_full_reset_o <= 1'b0;
			soft_restart_keep_regs_o <= 1'b0;
		end else if (ce_i) begin
			soft_full_reset_o <= soft_reset_req;
			soft_restart_keep_regs_o <= gen_reset[phy_ctrl_pkg::SOFT_RESTART_POS];
		end
	end

	// Shared pad: synchronised input, open-drain low-active interrupt output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_meta <= 1'b1;
			pad_sync <= 1'b1;
		end else if (ce_i) begin
			pad_meta <= irq_powerdown_pad_i;
			pad_sync <= pad_meta;
		end
	end

	// Pad driver: data stays low, the enable pulls the pad for an interrupt
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_powerdown_pad_o <= 1'b0;
			irq_powerdown_pad_oe_o <= 1'b0;
		end else if (ce_i) begin
			irq_powerdown_pad_o <= 1'b0;
			irq_powerdown_pad_oe_o <= general_config_four[phy_ctrl_pkg::IRQ_OE_POS] &&
				(irq_event_i || general_config_four[phy_ctrl_pkg::FORCE_IRQ_POS]);
		end
	end

	// Power-down request is read from the pad only while it is an input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_down_o <= 1'b0;
		end else if (ce_i) begin
			power_down_o <= !general_config_four[phy_ctrl_pkg::IRQ_OE_POS] && !pad_sync;
		end
	end

	// Blink timebase: phase toggles every half of the selected period
	always_comb begin
		unique case (lamp_blink[phy_ctrl_pkg::BLINK_SEL_POS +: 2])
			2'b00: blink_half = TW'(BLINK_HALF_0 - 1);
			2'b01: blink_half = TW'(BLINK_HALF_1 - 1);
			2'b10: blink_half = TW'(BLINK_HALF_2 - 1);
			2'b11: blink_half = TW'(BLINK_HALF_3 - 1);
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt <= '0;
			blink_phase <= 1'b0;
		end else if (ce_i) begin
			if (blink_cnt >= blink_half) begin
				blink_cnt <= '0;
				blink_phase <= !blink_phase;
			end else begin
				blink_cnt <= blink_cnt + TW'(1);
			end
		end
	end

	// Per-lamp source, stretch, force and polarity
	for (genvar k = 0; k < N; k++) begin : g_lamp
		localparam int B = k * phy_ctrl_pkg::LAMP_STRIDE;
		logic [TW-1:0] stretch_cnt;

		always_comb begin
			if (lamp_sel[k] == phy_ctrl_pkg::SRC_LINK_BLINK) begin
				lamp_raw[k] = lamp_events_i[phy_ctrl_pkg::SRC_LINK_BIT] &&
					(!lamp_events_i[phy_ctrl_pkg::SRC_ACT_BIT] || blink_phase);
			end else begin
				lamp_raw[k] = lamp_events_i[lamp_sel[k]];
			end
		end

		// Short pulses are held for half a blink period unless bypassed
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				stretch_cnt <= '0;
			end else if (ce_i) begin
				if (lamp_raw[k]) begin
					stretch_cnt <= blink_half;
				end else if (stretch_cnt != '0) begin
					stretch_cnt <= stretch_cnt - TW'(1);
				end
			end
		end

		assign lamp_shown[k] = lamp_blink[phy_ctrl_pkg::STRETCH_BYPASS_POS] ? lamp_raw[k] :
			(lamp_raw[k] || stretch_cnt != '0);

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				lamp_o[k] <= 1'b0;
			end else if (ce_i) begin
				if (lamp_ctrl[B + phy_ctrl_pkg::LAMP_FEN_POS]) begin
					lamp_o[k] <= !(lamp_ctrl[B + phy_ctrl_pkg::LAMP_FVAL_POS] ^
						lamp_ctrl[B + phy_ctrl_pkg::LAMP_POL_POS]);
				end else begin
					lamp_o[k] <= !(lamp_shown[k] ^ lamp_ctrl[B + phy_ctrl_pkg::LAMP_POL_POS]);
				end
			end
		end
	end
endmodule : phy_ctrl_regs

// file: sim/phy_ctrl_regs_asserts.sv
// Concurrent checks on the ports of the PHY control register bank
`timescale 1ns/1ps
module phy_ctrl_regs_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_powerdown_pad_i,
	input wire logic irq_powerdown_pad_o,
	input wire logic power_down_o,
	input wire logic reflectometry_start_o,
	input wire logic reflectometry_complete_i,
	input wire logic soft_full_reset_o,
	input wire logic soft_restart_keep_regs_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	ack_single_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held beyond one cycle");
	ack_answer_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	dat_upper_zero_a: assert property (wb_dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	dat_hold_a: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i))
		else $error("read data changed without a read");
	pad_open_drain_a: assert property (irq_powerdown_pad_o == 1'b0)
		else $error("pad data driven high");
	pd_cause_a: assert property ($rose(power_down_o) |-> !$past(irq_powerdown_pad_i, 3))
		else $error("power down without low pad");
	refl_launch_a: assert property ($rose(reflectometry_start_o) |-> $past(wb_ack_o && wb_we_i
		&& wb_adr_i[7:2] == phy_ctrl_pkg::IDX_GENERAL_CONFIG_FOUR && wb_sel_i[0] && wb_dat_i[0]))
		else $error("test started without a start write");
	refl_end_a: assert property ($fell(reflectometry_start_o)
		|-> $past(reflectometry_complete_i, 2) || $past(soft_full_reset_o))
		else $error("start cleared without completion");
	reset_pulse_a: assert property (soft_full_reset_o |-> $past(wb_ack_o && wb_we_i
		&& wb_adr_i[7:2] == phy_ctrl_pkg::IDX_GEN_RESET && wb_sel_i[1] && wb_dat_i[15])
		##1 !soft_full_reset_o)
		else $error("bad soft reset pulse");
	restart_pulse_a: assert property (soft_restart_keep_regs_o
		|-> ($past(wb_ack_o) || $past(wb_ack_o, 2)) ##1 !soft_restart_keep_regs_o)
		else $error("bad restart pulse");
endmodule : phy_ctrl_regs_asserts

bind phy_ctrl_regs phy_ctrl_regs_asserts chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_powerdown_pad_i,
	.irq_powerdown_pad_o, .power_down_o, .reflectometry_start_o, .reflectometry_complete_i,
	.soft_full_reset_o, .soft_restart_keep_regs_o);

// file: sim/led_and_phy_general_control_tb.sv
// Self-checking bench for the PHY control register bank
`timescale 1ns/1ps
module led_and_phy_general_control_tb;
	logic clk_i, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0, src = 0, strap = 4'ha, lamp_o;
	logic [31:0] wb_dat_i = 0, wb_dat_o;
	logic [15:0] events = 0;
	logic irq_event = 0, pad_ext = 1, pad_o, oe, pd, start_o, done_in = 0, fail_in = 0, sfr, srk;
	logic qne, pdfd, sc, rob, qx, gig, ce = 1'b1;
	logic [1:0] qsel;
	wire pad = pad_ext && !oe;
	int err_count = 0, n_checks = 0, n_sfr = 0, n_srk = 0, cyc_cnt = 0;
	localparam logic [15:0] LV [5] = '{16'h7777, 16'h3333, 16'h5555, 16'h7351, 16'h4444};
	localparam logic [3:0] LE [5] = '{4'hf, 4'h0, 4'h0, 4'h9, 4'hf};

	phy_ctrl_regs #(.BLINK_HALF_0(4), .BLINK_HALF_1(8), .BLINK_HALF_2(16), .BLINK_HALF_3(32)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lamp_events_i(events),
		.lamp0_source_select_i(src), .lamp1_source_select_i(src), .lamp2_source_select_i(src),
		.aux_lamp_source_select_i(src), .strap_polarity_i(strap), .lamp_o(lamp_o),
		.irq_event_i(irq_event), .irq_powerdown_pad_i(pad), .irq_powerdown_pad_o(pad_o),
		.irq_powerdown_pad_oe_o(oe), .power_down_o(pd), .quick_negotiation_enable_o(qne),
		.quick_negotiation_timer_sel_o(qsel), .parallel_detect_full_duplex_o(pdfd),
		.status_clear_o(sc), .robust_crossover_enable_o(rob), .quick_crossover_enable_o(qx),
		.gigabit_only_negotiation_o(gig), .reflectometry_start_o(start_o),
		.reflectometry_complete_i(done_in), .reflectometry_failed_i(fail_in),
		.soft_full_reset_o(sfr), .soft_restart_keep_regs_o(srk));

	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	// Pulse counters and hang guard
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (sfr === 1'b1) n_sfr++;
		if (srk === 1'b1) n_srk++;
		if (cyc_cnt == 20000) begin
			err_count++;
			summarize();
		end
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// One classic cycle; entered just after a rising edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'h3;
		wb_dat_i <= {16'h0000, d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		chk("ack", 32'(n), 32'h0000_0001);
		q = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] q;
		wb(1'b0, a, 16'h0000, q);
		chk(nm, 32'(q), 32'(exp));
	endtask : rdc
	task automatic flip(output int n);
		logic b;
		b = lamp_o[0];
		n = 0;
		while (lamp_o[0] === b && n < 100) begin
			@(posedge clk_i);
			n++;
		end
	endtask : flip

	task automatic t_reset;
		chk("lamp_o", 32'(lamp_o), 32'h0000_0005);
		rdc("lamp_ctrl", 8'h64, 16'h4040);
		rdc("blink", 8'h68, 16'h0002);
		rdc("cfg4", 8'h78, 16'h0012);
		rdc("gen_reset", 8'h7c, 16'h0000);
		wr(8'h00, 16'hffff);
		rdc("unmapped", 8'h00, 16'h0000);
		wr(8'h64, 16'hffff);
		rdc("lamp_ro", 8'h64, 16'h7777);
		wr(8'h68, 16'hffff);
		rdc("blink_ro", 8'h68, 16'h0007);
		wr(8'h78, 16'h0006);
		rdc("cfg4_ro", 8'h78, 16'h0002);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_lamp;
		events <= 16'h0001;
		foreach (LV[i]) begin
			wr(8'h64, LV[i]);
			tick(2);
			chk("lamp_o", 32'(lamp_o), 32'(LE[i]));
		end
		events <= 16'h0000;
		tick(3);
		chk("lamp_bypass", 32'(lamp_o), 32'h0000_0000);
		wr(8'h68, 16'h0000);
		events <= 16'h0001;
		tick(3);
		events <= 16'h0000;
		tick(3);
		chk("lamp_stretch", 32'(lamp_o), 32'h0000_000f);
		tick(8);
		chk("lamp_off", 32'(lamp_o), 32'h0000_0000);
		$display("t_lamp done");
	endtask : t_lamp
	task automatic t_blink;
		int n;
		src <= 4'hb;
		events <= 16'h0003;
		for (int s = 0; s < 4; s++) begin
			wr(8'h68, 16'h0004 | 16'(s));
			rdc("blink_sel", 8'h68, 16'h0004 | 16'(s));
			flip(n);
			flip(n);
			chk("blink_half", 32'(n), 32'(4 << s));
		end
		src <= 4'h0;
		events <= 16'h0000;
		$display("t_blink done");
	endtask : t_blink
	task automatic t_cfg;
		wr(8'h78, 16'h7f48);
		rdc("cfg4", 8'h78, 16'h7f4a);
		chk("cfg_out", 32'({qne, qsel, pdfd, sc, rob, qx, gig}), 32'h0000_00ff);
		wr(8'h78, 16'h2000);
		chk("cfg_out", 32'({qne, qsel, pdfd, sc, rob, qx, gig}), 32'h0000_0040);
		$display("t_cfg done");
	endtask : t_cfg
	task automatic t_irq;
		wr(8'h78, 16'h0080);
		irq_event <= 1'b1;
		tick(2);
		chk("irq_oe", 32'(oe), 32'h0000_0001);
		irq_event <= 1'b0;
		tick(2);
		chk("irq_oe", 32'(oe), 32'h0000_0000);
		wr(8'h78, 16'h00c0);
		chk("irq_force", 32'(oe), 32'h0000_0001);
		wr(8'h78, 16'h0040);
		pad_ext <= 1'b0;
		tick(5);
		chk("pd_mode", 32'({oe, pd}), 32'h0000_0001);
		wr(8'h78, 16'h0080);
		tick(2);
		chk("pd_off", 32'(pd), 32'h0000_0000);
		pad_ext <= 1'b1;
		$display("t_irq done");
	endtask : t_irq
	task automatic t_refl;
		for (int f = 1; f >= 0; f--) begin
			wr(8'h78, 16'h0001);
			rdc("refl_run", 8'h78, 16'h0001);
			chk("refl_start", 32'(start_o), 32'h0000_0001);
			done_in <= 1'b1;
			fail_in <= f[0];
			@(posedge clk_i);
			done_in <= 1'b0;
			tick(2);
			rdc("refl_end", 8'h78, 16'h0002 | 16'(f << 2));
			chk("refl_start", 32'(start_o), 32'h0000_0000);
		end
		$display("t_refl done");
	endtask : t_refl
	task automatic t_soft;
		wr(8'h64, 16'h0000);
		wr(8'h7c, 16'h4000);
		tick(3);
		chk("restart_pulses", 32'(n_srk), 32'h0000_0001);
		rdc("keep_regs", 8'h64, 16'h0000);
		rdc("restart_clr", 8'h7c, 16'h0000);
		strap <= 4'h5;
		wr(8'h68, 16'h0005);
		wr(8'h7c, 16'h8000);
		tick(3);
		chk("reset_pulses", 32'(n_sfr), 32'h0000_0001);
		rdc("strap_reload", 8'h64, 16'h4040);
		rdc("blink_dflt", 8'h68, 16'h0002);
		rdc("cfg4_dflt", 8'h78, 16'h0012);
		rdc("reset_clr", 8'h7c, 16'h0000);
		$display("t_soft done");
	endtask : t_soft
	task automatic t_ce;
		ce <= 1'b0;
		events <= 16'h0001;
		tick(4);
		chk("ce_freeze", 32'(lamp_o), 32'h0000_0005);
		ce <= 1'b1;
		tick(3);
		chk("ce_run", 32'(lamp_o), 32'h0000_000a);
		$display("t_ce done");
	endtask : t_ce

	initial begin
		tick(16);
		rst_i <= 1'b0;
		tick(3);
		t_reset();
		t_lamp();
		t_blink();
		t_cfg();
		t_irq();
		t_refl();
		t_soft();
		t_ce();
		summarize();
	end
endmodule : led_and_phy_general_control_tb
